/* File: aesb_pkg.sv */
// Package with constants, carrier types and GF(2^8) helpers for the AES block engine
`default_nettype none

package aesb_pkg;

   // ==========================================================
   // Sizes and timing
   localparam int unsigned AESB_BLOCK_BYTES = 16;          // Bytes in state and key memory
   localparam int unsigned AESB_ROUNDS      = 10;          // Rounds for a 128-bit key
   localparam int unsigned AESB_RUN_CYCLES  = 375;         // Cycles from start to done
   localparam logic [8:0]  AESB_LAST_CYCLE  = 9'(AESB_RUN_CYCLES - 1);
   localparam logic [8:0]  AESB_ENC_LAST    = 9'd10;       // Last working cycle, encryption
   localparam logic [8:0]  AESB_DEC_ADDKEY  = 9'd10;       // Decryption: first key addition
   localparam logic [8:0]  AESB_DEC_LAST    = 9'd20;       // Last working cycle, decryption
   localparam logic [8:0]  AESB_DEC_BASE    = 9'd21;       // Round index = base - cycle
   localparam logic [3:0]  AESB_PTR_LAST    = 4'hF;        // Byte pointer wrap point
   localparam logic [7:0]  AESB_AFF_FWD     = 8'h63;       // Forward affine constant
   localparam logic [7:0]  AESB_AFF_INV     = 8'h05;       // Inverse affine constant
   localparam logic [7:0]  AESB_POLY        = 8'h1B;       // Field reduction polynomial

   // ==========================================================
   // Carrier types
   typedef struct packed {
      logic       keyWr;      // Write one key byte
      logic       stateWr;    // Write (or XOR in) one state byte
      logic       stateRd;    // Read one state byte
      logic       ptrClr;     // Return both byte pointers to position 0
      logic       start;      // Begin one operation
      logic [7:0] data;       // Write data
   } aesb_req_t;

   typedef struct packed {
      logic decrypt;          // 1 = decrypt, 0 = encrypt
      logic xorLoad;          // State writes XOR into the stored byte
      logic autoStart;        // Start once all 16 state bytes are written
      logic irqEn;            // Pass completion onto the interrupt line
   } aesb_cfg_t;

   typedef struct packed {
      logic busy;             // Operation in progress
      logic done;             // Result ready, held until next start
      logic irq;              // Completion interrupt, level
      logic dmaTrig;          // One-cycle DMA transfer trigger
   } aesb_stat_t;

   // ==========================================================
   // Field arithmetic
   function automatic logic [7:0] aesb_xtime(input logic [7:0] a);
      aesb_xtime = {a[6:0], 1'b0} ^ (a[7] ? AESB_POLY : 8'h00);
   endfunction : aesb_xtime

   function automatic logic [7:0] aesb_gmul(input logic [7:0] a, input logic [7:0] b);
      logic [7:0] p;
      logic [7:0] x;
      p = 8'h00;
      x = a;
      for (int i = 0; i < 8; i++)
      begin
         if (b[i])
            p = p ^ x;
         x = aesb_xtime(x);
      end
      aesb_gmul = p;
   endfunction : aesb_gmul

   // Multiplicative inverse as x^254; zero maps to zero
   function automatic logic [7:0] aesb_ginv(input logic [7:0] a);
      logic [7:0] r;
      logic [7:0] p;
      r = 8'h01;
      p = a;
      for (int i = 1; i < 8; i++)
      begin
         p = aesb_gmul(p, p);
         r = aesb_gmul(r, p);
      end
      aesb_ginv = r;
   endfunction : aesb_ginv

   function automatic logic [7:0] aesb_rotl(input logic [7:0] a, input int unsigned n);
      aesb_rotl = (a << n) | (a >> (8 - n));
   endfunction : aesb_rotl

   // Round constant for a key schedule step 1..10
   function automatic logic [7:0] aesb_rcon(input logic [3:0] idx);
      logic [7:0] r;
      r = 8'h01;
      for (int i = 2; i <= 10; i++)
      begin
         if (i <= idx)
            r = aesb_xtime(r);
      end
      aesb_rcon = r;
   endfunction : aesb_rcon

   // Byte n of a block, byte 0 in the top bits
   function automatic logic [7:0] aesb_byte(input logic [127:0] s, input logic [3:0] n);
      aesb_byte = s[8'd127 - {n, 3'b000} -: 8];
   endfunction : aesb_byte

   // Row shift, forward or inverse; byte 4c+r is row r, column c
   function automatic logic [127:0] aesb_shift(input logic [127:0] s, input logic inv);
      logic [127:0] o;
      o = '0;
      for (int c = 0; c < 4; c++)
      begin
         for (int r = 0; r < 4; r++)
         begin
            o[127 - 8*(4*c + r) -: 8] = inv ? s[127 - 8*(4*((c + 4 - r) % 4) + r) -: 8]
                                            : s[127 - 8*(4*((c + r) % 4) + r) -: 8];
         end
      end
      aesb_shift = o;
   endfunction : aesb_shift

   // Column mix, forward or inverse
   function automatic logic [127:0] aesb_mix(input logic [127:0] s, input logic inv);
      logic [127:0] o;
      logic [7:0]   k0;
      logic [7:0]   k1;
      logic [7:0]   k2;
      logic [7:0]   k3;
      logic [7:0]   a [4];
      o  = '0;
      k0 = inv ? 8'h0E : 8'h02;
      k1 = inv ? 8'h0B : 8'h03;
      k2 = inv ? 8'h0D : 8'h01;
      k3 = inv ? 8'h09 : 8'h01;
      for (int c = 0; c < 4; c++)
      begin
         for (int r = 0; r < 4; r++)
            a[r] = s[127 - 8*(4*c + r) -: 8];
         for (int r = 0; r < 4; r++)
         begin
            o[127 - 8*(4*c + r) -: 8] = aesb_gmul(a[r], k0) ^ aesb_gmul(a[(r+1)%4], k1)
                                      ^ aesb_gmul(a[(r+2)%4], k2) ^ aesb_gmul(a[(r+3)%4], k3);
         end
      end
      aesb_mix = o;
   endfunction : aesb_mix

endpackage : aesb_pkg

`default_nettype wire

/* File: aesb_sbox.sv */
// Byte substitution box, forward or inverse, computed from field inversion
`default_nettype none

module aesb_sbox
(
   // Byte path
   input  wire logic [7:0] din,
   input  wire logic       inv,
   output logic      [7:0] dout
);
   import aesb_pkg::*;

   // ==========================================================
   // Substitution
   // No table: the inverse is computed, trading depth for area
   logic [7:0] fwdVal;
   logic [7:0] preInv;
   logic [7:0] invVal;

   assign fwdVal = aesb_ginv(din) ^ aesb_rotl(aesb_ginv(din), 1) ^ aesb_rotl(aesb_ginv(din), 2)
                 ^ aesb_rotl(aesb_ginv(din), 3) ^ aesb_rotl(aesb_ginv(din), 4) ^ AESB_AFF_FWD;
   assign preInv = aesb_rotl(din, 1) ^ aesb_rotl(din, 3) ^ aesb_rotl(din, 6) ^ AESB_AFF_INV;
   assign invVal = aesb_ginv(preInv);
   assign dout   = inv ? invVal : fwdVal;

endmodule : aesb_sbox

`default_nettype wire

/* File: aesb_engine.sv */
// AES-128 block engine with byte-wide key and state loading, fixed-latency run
`default_nettype none

module aesb_engine
(
   // Clock and reset
   input  wire logic              core_clk,
   input  wire logic              resetn,
   // Host requests and configuration
   input  wire aesb_pkg::aesb_req_t req,
   input  wire aesb_pkg::aesb_cfg_t cfg,
   // Answers
   output logic            [7:0]  rdData_r,
   output aesb_pkg::aesb_stat_t   stat_r
);
   import aesb_pkg::*;

   // ==========================================================
   // Storage and control state
   logic [127:0] keyMem_r;      // User key, kept for the next block
   logic [127:0] state_r;       // State memory, also the working block
   logic [127:0] rk_r;          // Working round key
   logic [3:0]   keyPtr_r;
   logic [3:0]   statePtr_r;
   logic [8:0]   cnt_r;
   logic         decOp_r;       // Direction latched at start

   // ==========================================================
   // Host access decode; memories are locked while busy
   logic idle;
   logic keyWrOk;
   logic stateWrOk;
   logic stateRdOk;
   logic lastByteWr;
   logic startNow;
   logic finish;

   assign idle       = !stat_r.busy;
   assign keyWrOk    = idle && req.keyWr;
   assign stateWrOk  = idle && req.stateWr;
   assign stateRdOk  = idle && req.stateRd;
   assign lastByteWr = stateWrOk && (statePtr_r == AESB_PTR_LAST);
   assign startNow   = idle && (req.start || (cfg.autoStart && lastByteWr));
   assign finish     = stat_r.busy && (cnt_r == AESB_LAST_CYCLE);

   // ==========================================================
   // Write data: plain store or XOR into the stored byte
   logic [7:0] oldByte;
   logic [7:0] newByte;

   assign oldByte = aesb_byte(state_r, statePtr_r);
   assign newByte = cfg.xorLoad ? (oldByte ^ req.data) : req.data;

   // ==========================================================
   // Schedule decode for the working cycles
   logic       encAdd;
   logic       encRound;
   logic       decExpand;
   logic       decAdd;
   logic       decRound;
   logic       lastRound;
   logic [3:0] fwdIdx;
   logic [3:0] revIdx;

   assign encAdd    = stat_r.busy && !decOp_r && (cnt_r == 9'd0);
   assign encRound  = stat_r.busy && !decOp_r && (cnt_r != 9'd0) && (cnt_r <= AESB_ENC_LAST);
   assign decExpand = stat_r.busy && decOp_r && (cnt_r < AESB_DEC_ADDKEY);
   assign decAdd    = stat_r.busy && decOp_r && (cnt_r == AESB_DEC_ADDKEY);
   assign decRound  = stat_r.busy && decOp_r && (cnt_r > AESB_DEC_ADDKEY)
                   && (cnt_r <= AESB_DEC_LAST);
   assign lastRound = (!decOp_r && cnt_r == AESB_ENC_LAST) || (decOp_r && cnt_r == AESB_DEC_LAST);
   assign fwdIdx    = decOp_r ? 4'(cnt_r + 9'd1) : cnt_r[3:0];
   assign revIdx    = 4'(AESB_DEC_BASE - cnt_r);

   // ==========================================================
   // Key schedule: one step forward or one step back per cycle
   logic [31:0] w0;
   logic [31:0] w1;
   logic [31:0] w2;
   logic [31:0] w3;
   logic [31:0] gIn;
   logic [31:0] gSub;
   logic [31:0] gWord;
   logic [7:0]  rcon;
   logic [127:0] rkNext;
   logic [127:0] rkPrev;

   assign {w0, w1, w2, w3} = rk_r;
   assign gIn   = decRound ? (w3 ^ w2) : w3;            // Backward step rebuilds old word 3
   assign rcon  = aesb_rcon(decRound ? revIdx : fwdIdx);
   assign gWord = gSub ^ {rcon, 24'h000000};

   genvar gk;
   generate
      for (gk = 0; gk < 4; gk++)
      begin : g_key_sbox
         // Rotated word: byte k takes byte k+1
         aesb_sbox u_sbox
         (
            .din  (gIn[31 - 8*((gk + 1) % 4) -: 8]),
            .inv  (1'b0),
            .dout (gSub[31 - 8*gk -: 8])
         );
      end
   endgenerate

   assign rkNext = {w0 ^ gWord, w0 ^ gWord ^ w1, w0 ^ gWord ^ w1 ^ w2,
                    w0 ^ gWord ^ w1 ^ w2 ^ w3};
   assign rkPrev = {w0 ^ gWord, w1 ^ w0, w2 ^ w1, w3 ^ w2};

   // ==========================================================
   // Round datapath, forward or inverse
   logic [127:0] shifted;
   logic [127:0] subbed;
   logic [127:0] encOut;
   logic [127:0] decKeyed;
   logic [127:0] decOut;

   assign shifted = aesb_shift(state_r, decOp_r);

   genvar gs;
   generate
      for (gs = 0; gs < AESB_BLOCK_BYTES; gs++)
      begin : g_state_sbox
         aesb_sbox u_sbox
         (
            .din  (shifted[127 - 8*gs -: 8]),
            .inv  (decOp_r),
            .dout (subbed[127 - 8*gs -: 8])
         );
      end
   endgenerate

   // Forward: shift, sub, mix, key. Inverse: shift, sub, key, unmix
   assign encOut   = (lastRound ? subbed : aesb_mix(subbed, 1'b0)) ^ rkNext;
   assign decKeyed = subbed ^ rkPrev;
   assign decOut   = lastRound ? decKeyed : aesb_mix(decKeyed, 1'b1);

   // ==========================================================
   // Next values of the working registers
   logic [127:0] state_nxt;
   logic [127:0] rk_nxt;

   always_comb
   begin
      state_nxt = state_r;
      rk_nxt    = rk_r;
      if (startNow)
         rk_nxt = keyMem_r;                           // Key memory must already hold the key
      else if (encAdd || decAdd)
         state_nxt = state_r ^ rk_r;
      else if (encRound)
      begin
         state_nxt = encOut;
         rk_nxt    = rkNext;
      end
      else if (decExpand)
         rk_nxt = rkNext;
      else if (decRound)
      begin
         state_nxt = decOut;
         rk_nxt    = rkPrev;
      end
      if (stateWrOk)
         state_nxt[8'd127 - {statePtr_r, 3'b000} -: 8] = newByte;
   end

   // ==========================================================
   // Memories and round key
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_r  <= '0;
         rk_r     <= '0;
         keyMem_r <= '0;
      end
      else
      begin
         state_r <= state_nxt;
         rk_r    <= rk_nxt;
         if (keyWrOk)
            keyMem_r[8'd127 - {keyPtr_r, 3'b000} -: 8] <= req.data;
      end
   end

   // ==========================================================
   // Byte pointers; each access steps one position and wraps after 15
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         keyPtr_r   <= '0;
         statePtr_r <= '0;
      end
      else if (req.ptrClr && idle)
      begin
         keyPtr_r   <= '0;
         statePtr_r <= '0;
      end
      else
      begin
         if (keyWrOk)
            keyPtr_r <= keyPtr_r + 4'h1;
         if (stateWrOk || stateRdOk)
            statePtr_r <= statePtr_r + 4'h1;
      end
   end

   // ==========================================================
   // Read data, taken from the byte under the pointer
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         rdData_r <= '0;
      else if (stateRdOk)
         rdData_r <= oldByte;
   end

   // ==========================================================
   // Run counter and status; done holds until the next start
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         cnt_r   <= '0;
         decOp_r <= 1'b0;
         stat_r  <= '0;
      end
      else
      begin
         stat_r.dmaTrig <= finish;
         if (startNow)
         begin
            cnt_r       <= '0;
            decOp_r     <= cfg.decrypt;
            stat_r.busy <= 1'b1;
            stat_r.done <= 1'b0;
            stat_r.irq  <= 1'b0;
         end
         else if (finish)
         begin
            stat_r.busy <= 1'b0;
            stat_r.done <= 1'b1;
            stat_r.irq  <= cfg.irqEn;
         end
         else
         begin
            if (stat_r.busy)
               cnt_r <= cnt_r + 9'd1;
            stat_r.irq <= stat_r.done && cfg.irqEn;
         end
      end
   end

endmodule : aesb_engine

`default_nettype wire

/* File: aesb_engine_sva.sv */
// Port checker for the AES block engine
`default_nettype none

module aesb_engine_sva
(
   // Clock and reset
   input  wire logic                 core_clk,
   input  wire logic                 resetn,
   // Watched ports
   input  wire aesb_pkg::aesb_req_t  req,
   input  wire aesb_pkg::aesb_cfg_t  cfg,
   input  wire logic           [7:0] rdData_r,
   input  wire aesb_pkg::aesb_stat_t stat_r
);
   timeunit 1ns;
   timeprecision 100ps;
   import aesb_pkg::*;

   // ==========================================================
   // Helper logic
   logic [8:0] runCnt_r;
   logic [3:0] sPtr_r;
   // A start is either the strobe or the write that fills byte 15 in auto mode
   wire  logic startTaken = !stat_r.busy
                         && (req.start || (cfg.autoStart && req.stateWr && sPtr_r == 4'hF));
   wire  logic stepTaken  = !stat_r.busy && (req.stateWr || req.stateRd);

   // Run length and state pointer, tracked from the port traffic only
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         runCnt_r <= 9'h000;
         sPtr_r   <= 4'h0;
      end
      else
      begin
         runCnt_r <= stat_r.busy ? runCnt_r + 9'h001 : 9'h000;
         if (req.ptrClr && !stat_r.busy)
            sPtr_r <= 4'h0;
         else if (stepTaken)
            sPtr_r <= sPtr_r + 4'h1;
      end
   end

   // ==========================================================
   // Assertions
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);

   a_start_to_busy: assert property (startTaken |=> stat_r.busy)
      else $error("start did not raise busy");
   a_run_length: assert property ($fell(stat_r.busy) |-> runCnt_r == 9'(AESB_RUN_CYCLES))
      else $error("run length wrong");
   a_done_at_end: assert property ($fell(stat_r.busy) |-> stat_r.done && stat_r.dmaTrig)
      else $error("no done or trigger at end of run");
   a_trig_on_finish: assert property (stat_r.dmaTrig |-> $fell(stat_r.busy))
      else $error("trigger outside run end");
   a_trig_single: assert property (stat_r.dmaTrig |=> !stat_r.dmaTrig)
      else $error("trigger longer than one cycle");
   a_done_clears: assert property (startTaken |=> !stat_r.done)
      else $error("done kept over a start");
   a_irq_masked: assert property (!cfg.irqEn |=> !stat_r.irq)
      else $error("interrupt while disabled");
   a_irq_raised: assert property (stat_r.done && cfg.irqEn && !startTaken |=> stat_r.irq)
      else $error("interrupt missing");
   a_auto_start: assert property (cfg.autoStart && req.stateWr && !req.ptrClr && !stat_r.busy
      && sPtr_r == 4'hF |=> stat_r.busy)
      else $error("auto start missed");
   a_no_spurious: assert property (!stat_r.busy && !req.start
      && !(cfg.autoStart && req.stateWr) |=> !stat_r.busy)
      else $error("run began without a cause");
   a_read_holds: assert property (!(req.stateRd && !stat_r.busy) |=> $stable(rdData_r))
      else $error("read data changed without a read");

   // Main scenarios reached
   c_decrypt: cover property (startTaken && cfg.decrypt);
   c_auto: cover property ($rose(stat_r.busy) && cfg.autoStart);
   c_irq: cover property (stat_r.irq && stat_r.dmaTrig);

endmodule : aesb_engine_sva

`default_nettype wire

/* File: aesb_host_model.sv */
// Host model: the core or DMA side that loads, starts and reads the engine
`default_nettype none

module aesb_host_model
(
   // Clock
   input  wire logic                 core_clk,
   // Engine side
   input  wire logic           [7:0] rdData_r,
   output var  aesb_pkg::aesb_req_t  req
);
   timeunit 1ns;
   timeprecision 100ps;
   import aesb_pkg::*;

   initial req = '0;

   // One request at a falling edge, held over the taking rising edge
   task automatic pulse(input int unsigned kind, input logic [7:0] d);
      aesb_req_t r;
      r      = '0;
      r.data = d;
      case (kind)
         0: r.keyWr   = 1'b1;
         1: r.stateWr = 1'b1;
         2: r.stateRd = 1'b1;
         3: r.ptrClr  = 1'b1;
         default: r.start = 1'b1;
      endcase
      req = r;
      @(negedge core_clk);
   endtask : pulse

   // Released data line shows the inverse so a stale byte is never reused
   task automatic idle();
      req = {5'b00000, ~req.data};
   endtask : idle

   // Whole block, most significant byte first; done before any start
   task automatic load(input int unsigned kind, input logic [127:0] blk);
      for (int i = 0; i < 16; i++)
         pulse(kind, blk[127 - 8*i -: 8]);
   endtask : load

   // Read data is valid at the falling edge after the taking edge
   task automatic read(output logic [127:0] blk);
      for (int i = 0; i < 16; i++)
      begin
         pulse(2, 8'h00);
         blk[127 - 8*i -: 8] = rdData_r;
      end
   endtask : read

endmodule : aesb_host_model

`default_nettype wire

/* File: tb_aesb_engine.sv */
// Self-checking testbench for the AES block engine
`default_nettype none

module tb_aesb_engine;
   timeunit 1ns;
   timeprecision 100ps;
   import aesb_pkg::*;

   // ==========================================================
   // Signals
   logic       core_clk = 1'b0;
   logic       resetn   = 1'b0;
   aesb_cfg_t  cfg      = '0;
   aesb_req_t  req;
   logic [7:0] rdData_r;
   aesb_stat_t stat_r;
   int         fails      = 0;
   int         n_compared = 0;
   int         cyc        = 0;

   // 40 MHz clock
   always #12.5 core_clk = ~core_clk;

   aesb_host_model host_u (.core_clk(core_clk), .rdData_r(rdData_r), .req(req));
   aesb_engine dut_u (.core_clk(core_clk), .resetn(resetn), .req(req), .cfg(cfg),
                      .rdData_r(rdData_r), .stat_r(stat_r));

   // ==========================================================
   // Compare and closing tasks
   task automatic cmp_blk(input logic [127:0] g, input logic [127:0] e);
      n_compared++;
      if (g !== e)
      begin
         fails++;
         $display("FAIL at %0t: block %h expected %h", $time, g, e);
      end
   endtask : cmp_blk

   task automatic cmp_bit(input logic g, input logic e);
      n_compared++;
      if (g !== e)
      begin
         fails++;
         $display("FAIL at %0t: flag %b expected %b", $time, g, e);
      end
   endtask : cmp_bit

   task automatic cmp_int(input int g, input int e);
      n_compared++;
      if (g != e)
      begin
         fails++;
         $display("FAIL at %0t: count %0d expected %0d", $time, g, e);
      end
   endtask : cmp_int

   task automatic end_of_test();
      $display("compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : end_of_test

   // One operation; stray requests while busy must be ignored
   task automatic run(input logic dec, input logic [127:0] st, output logic [127:0] res);
      int k;
      cfg.decrypt = dec;
      host_u.pulse(3, 8'h00);
      host_u.load(1, st);
      if (!cfg.autoStart)
         host_u.pulse(4, 8'h00);
      host_u.idle();
      cmp_bit(stat_r.busy, 1'b1);
      repeat (100) @(negedge core_clk);
      host_u.pulse(0, 8'hFF);
      host_u.pulse(4, 8'hFF);
      host_u.idle();
      k = 102;
      while (stat_r.done !== 1'b1 && k < 400)
      begin
         @(negedge core_clk);
         k++;
      end
      cmp_int(k, AESB_RUN_CYCLES);
      cmp_bit(stat_r.dmaTrig, 1'b1);
      cmp_bit(stat_r.irq, cfg.irqEn);
      @(negedge core_clk);
      cmp_bit(stat_r.dmaTrig, 1'b0);
      host_u.pulse(3, 8'h00);
      host_u.read(res);
   endtask : run

   // Cut a hang short
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         fails++;
         end_of_test();
      end
   end

   // ==========================================================
   // Main sequence
   initial
   begin
      logic [127:0] key;
      logic [127:0] pt;
      logic [127:0] ct;
      logic [127:0] r;
      logic [127:0] x;
      void'($urandom(37));
      key = 128'h000102030405060708090A0B0C0D0E0F;
      pt  = 128'h00112233445566778899AABBCCDDEEFF;
      ct  = 128'h69C4E0D86A7B0430D8CDB78070B4C55A;
      repeat (6) @(negedge core_clk);
      resetn = 1'b1;
      host_u.load(0, key);
      cfg.irqEn = 1'b1;
      run(1'b0, pt, x);
      cmp_blk(x, ct);
      cfg.irqEn = 1'b0;
      run(1'b1, ct, x);
      cmp_blk(x, pt);
      // XOR load over a random state, after partial reads and a pointer clear
      r = {$urandom, $urandom, $urandom, $urandom};
      host_u.load(1, r);
      repeat (5) host_u.pulse(2, 8'h00);
      host_u.pulse(3, 8'h00);
      cfg.xorLoad = 1'b1;
      host_u.load(1, pt ^ r);
      cfg.xorLoad = 1'b0;
      host_u.read(x);
      cmp_blk(x, pt);
      // Random round trips, auto start on every other one
      repeat (4)
      begin
         key = {$urandom, $urandom, $urandom, $urandom};
         pt  = {$urandom, $urandom, $urandom, $urandom};
         cfg.autoStart = ~cfg.autoStart;
         cfg.irqEn = 1'($urandom);
         host_u.load(0, key);
         run(1'b0, pt, ct);
         run(1'b1, ct, x);
         cmp_blk(x, pt);
      end
      end_of_test();
   end

endmodule : tb_aesb_engine

bind aesb_engine aesb_engine_sva chk_u (.core_clk(core_clk), .resetn(resetn), .req(req),
   .cfg(cfg), .rdData_r(rdData_r), .stat_r(stat_r));

`default_nettype wire
